// *** amm_pkg.sv ***
// audio matrix mixer: shared constants, reset values and state type
// assumes one sample-clock domain and a synchronous active-low reset
package amm_pkg;
   //----------------------------------------------------------------
   // sizes
   //----------------------------------------------------------------
   localparam int SAMPLE_W   = 24;  // signed audio sample
   localparam int GAIN_W     = 16;  // signed gain word
   localparam int GAIN_FRAC  = 12;  // fraction bits of a gain
   localparam int NCH        = 256; // inputs, playback and outputs each
   localparam int NSUB       = 128; // stereo submixes, output pairs
   localparam int FIFO_DEPTH = 32;  // source fifo words
   localparam int RMS_SHIFT  = 8;   // mean-square leak, 2**-8 per sample
   localparam int MS_W       = 48;  // mean-square word
   //----------------------------------------------------------------
   // values and reset values
   //----------------------------------------------------------------
   localparam logic signed [SAMPLE_W-1:0] SMAX = 24'sh7FFFFF;
   localparam logic signed [SAMPLE_W-1:0] SMIN = 24'sh800000;
   localparam logic [SAMPLE_W-1:0]        PEAK_RST  = 24'h000000;
   localparam logic [MS_W-1:0]            MS_RST    = 48'h000000000000;
   localparam logic [SAMPLE_W-1:0]        SMP_RST   = 24'h000000;
   localparam logic [GAIN_W-1:0]          OGAIN_RST = 16'h1000; // unity
   //----------------------------------------------------------------
   // sequencer states
   //----------------------------------------------------------------
   typedef enum logic [1:0] {ST_LOAD, ST_MIX, ST_FIN, ST_EMIT} amm_state_t;
endpackage

// *** amm_mixer.sv ***
// audio matrix mixer: source fifo plus the mixing sequencer and meters
// assumes all ports sit on clk; the host keeps sources in frame order
`timescale 1ns/1ps

//------------------------------------------------------------------
// synchronous fifo with valid/ready on both sides
//------------------------------------------------------------------
module amm_fifo #(
   parameter int W     = 34,
   parameter int DEPTH = amm_pkg::FIFO_DEPTH
) (
   input  wire logic         clk,       // sample clock
   input  wire logic         reset_n,   // sync reset, low
   input  wire logic         in_valid,  // write request
   output logic              in_ready,  // room left
   input  wire logic [W-1:0] in_data,   // write word
   output logic              out_valid, // word waiting
   input  wire logic         out_ready, // reader takes word
   output logic [W-1:0]      out_data   // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0]  wp_r, wp_nxt;
   logic [AW:0]  rp_r, rp_nxt;
   logic         wr;

   // full and empty from pointers with a wrap bit
   always_comb
   begin
      in_ready  = (wp_r[AW-1:0] != rp_r[AW-1:0]) || (wp_r[AW] == rp_r[AW]);
      out_valid = (wp_r != rp_r);
      out_data  = mem[rp_r[AW-1:0]];
      wr        = in_valid && in_ready;
      wp_nxt    = wr ? wp_r + 1'b1 : wp_r;
      rp_nxt    = (out_valid && out_ready) ? rp_r + 1'b1 : rp_r;
   end

   // pointer and storage registers
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         wp_r <= '0;
         rp_r <= '0;
      end
      else
      begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
      if (wr)
         mem[wp_r[AW-1:0]] <= in_data;
   end
endmodule

//------------------------------------------------------------------
// matrix mixer top
//------------------------------------------------------------------
module amm_mixer #(
   parameter int NCH = amm_pkg::NCH,
   parameter int SW  = $clog2(2 * NCH),
   parameter int OW  = $clog2(NCH),
   parameter int MW  = $clog2(3 * NCH)
) (
   input  wire logic                         clk,        // 40 MHz sample clock
   input  wire logic                         reset_n,    // sync reset, low
   input  wire logic                         in_valid,   // source sample valid
   output logic                              in_ready,   // fifo has room
   input  wire logic [amm_pkg::SAMPLE_W-1:0] in_data,    // source sample
   input  wire logic [SW-1:0]                in_src,     // msb set: playback
   input  wire logic                         in_last,    // last source of frame
   output logic                              rec_valid,  // record sample valid
   input  wire logic                         rec_ready,  // host takes record
   output logic [amm_pkg::SAMPLE_W-1:0]      rec_data,   // record sample
   output logic [OW-1:0]                     rec_chan,   // record channel
   output logic                              out_valid,  // output sample valid
   input  wire logic                         out_ready,  // output taken
   output logic [amm_pkg::SAMPLE_W-1:0]      out_data,   // mixed output sample
   output logic [OW-1:0]                     out_chan,   // output channel
   input  wire logic [NCH-1:0]               loop_en,    // loopback per channel
   input  wire logic                         gain_we,    // routing gain write
   input  wire logic [OW-1:0]                gain_dst,   // routing target
   input  wire logic [SW-1:0]                gain_src,   // routing source
   input  wire logic [amm_pkg::GAIN_W-1:0]   gain_val,   // routing gain
   input  wire logic                         og_we,      // output gain write
   input  wire logic [OW-1:0]                og_dst,     // output channel
   input  wire logic [amm_pkg::GAIN_W-1:0]   og_val,     // output gain
   input  wire logic [MW-1:0]                meter_sel,  // meter to read
   input  wire logic                         meter_clr,  // clear selected peak
   output logic [amm_pkg::SAMPLE_W-1:0]      meter_peak, // peak magnitude
   output logic [amm_pkg::MS_W-1:0]          meter_ms    // mean square
);
   localparam int DW  = amm_pkg::SAMPLE_W;
   localparam int GW  = amm_pkg::GAIN_W;
   localparam int AW  = DW + GW + SW; // no overflow over all sources
   localparam int FW  = DW + SW + 1;
   localparam int NM  = 3 * NCH;
   localparam logic [SW-1:0] S_LAST = SW'(2 * NCH - 1);
   localparam logic [OW-1:0] O_LAST = OW'(NCH - 1);

   // clamp a wide value to the sample range
   function automatic logic signed [DW-1:0] sat(input logic signed [AW-1:0] v);
      if (v > AW'(amm_pkg::SMAX))
         sat = amm_pkg::SMAX;
      else if (v < AW'(amm_pkg::SMIN))
         sat = amm_pkg::SMIN;
      else
         sat = v[DW-1:0];
   endfunction

   //---------------------------------------------------------------
   // source fifo
   //---------------------------------------------------------------
   logic          f_valid, pop, f_last;
   logic [FW-1:0] f_word;
   amm_fifo #(.W(FW), .DEPTH(amm_pkg::FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (in_valid),
      .in_ready  (in_ready),
      .in_data   ({in_last, in_src, in_data}),
      .out_valid (f_valid),
      .out_ready (pop),
      .out_data  (f_word)
   );
   logic [SW-1:0]        f_src;
   logic signed [DW-1:0] f_data;
   assign {f_last, f_src, f_data} = f_word;

   //---------------------------------------------------------------
   // storage, sequencer, record path and output state
   //---------------------------------------------------------------
   logic signed [DW-1:0] x_mem    [2 * NCH];
   logic signed [GW-1:0] gain_mem [2 * NCH * NCH];
   logic signed [GW-1:0] og_mem   [NCH];
   logic signed [DW-1:0] last_mem [NCH];
   logic [DW-1:0]        peak_mem [NM];
   logic [amm_pkg::MS_W-1:0] ms_mem [NM];
   amm_pkg::amm_state_t  st_r, st_nxt;
   logic [SW-1:0]        s_r, s_nxt;
   logic [OW-1:0]        o_r, o_nxt, rc_r, rc_nxt;
   logic signed [AW-1:0] acc_r, acc_nxt, scaled;
   logic                 rv_r, rv_nxt, ov_r, ov_nxt, m_we;
   logic [DW-1:0]        rd_r, rd_nxt, od_r, od_nxt, m_mag, pk_r, pk_nxt;
   logic signed [DW-1:0] sum, post, m_smp;
   logic [MW-1:0]        m_idx;
   logic [2*DW-1:0]      m_sq;
   logic [amm_pkg::MS_W-1:0] ms_new, ms_r, ms_nxt;

   // next-state logic of the whole datapath
   always_comb
   begin
      st_nxt = st_r;
      s_nxt  = s_r;
      o_nxt  = o_r;
      acc_nxt = acc_r;
      rv_nxt = rv_r && !rec_ready;
      rd_nxt = rd_r;
      rc_nxt = rc_r;
      ov_nxt = ov_r;
      od_nxt = od_r;
      pop    = (st_r == amm_pkg::ST_LOAD) && f_valid && !(rv_r && !rec_ready);
      sum    = sat(acc_r >>> amm_pkg::GAIN_FRAC);
      scaled = AW'((sum * og_mem[o_r]) >>> amm_pkg::GAIN_FRAC);
      post   = sat(scaled);
      m_we   = 1'b0;
      m_idx  = MW'(f_src);
      m_smp  = f_data;
      unique case (st_r)
         amm_pkg::ST_LOAD:
         begin
            if (pop && !f_src[SW-1])
            begin
               rv_nxt = 1'b1;
               rc_nxt = f_src[OW-1:0];
               rd_nxt = loop_en[f_src[OW-1:0]] ? last_mem[f_src[OW-1:0]] : f_data;
            end
            m_we = pop;
            if (pop && f_last)
            begin
               st_nxt  = amm_pkg::ST_MIX;
               s_nxt   = '0;
               o_nxt   = '0;
               acc_nxt = '0;
            end
         end
         amm_pkg::ST_MIX:
         begin
            // one weighted source per cycle into the current output
            acc_nxt = acc_r + AW'(x_mem[s_r] * gain_mem[{o_r, s_r}]);
            s_nxt   = s_r + 1'b1;
            if (s_r == S_LAST)
               st_nxt = amm_pkg::ST_FIN;
         end
         amm_pkg::ST_FIN:
         begin
            ov_nxt = 1'b1;
            od_nxt = post;
            m_we   = 1'b1;
            m_idx  = MW'(2 * NCH) + MW'(o_r);
            m_smp  = post;
            st_nxt = amm_pkg::ST_EMIT;
         end
         amm_pkg::ST_EMIT:
         begin
            if (out_ready)
            begin
               ov_nxt  = 1'b0;
               acc_nxt = '0;
               s_nxt   = '0;
               o_nxt   = o_r + 1'b1;
               st_nxt  = (o_r == O_LAST) ? amm_pkg::ST_LOAD : amm_pkg::ST_MIX;
            end
         end
      endcase
      // meter update: peak hold and leaky mean square
      m_mag  = m_smp[DW-1] ? DW'(-m_smp) : DW'(m_smp);
      m_sq   = m_mag * m_mag;
      ms_new = ms_mem[m_idx] - (ms_mem[m_idx] >> amm_pkg::RMS_SHIFT)
               + (m_sq >> amm_pkg::RMS_SHIFT);
      pk_nxt = peak_mem[meter_sel];
      ms_nxt = ms_mem[meter_sel];
   end

   // registers and memories
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         st_r  <= amm_pkg::ST_LOAD;
         s_r   <= '0;
         o_r   <= '0;
         acc_r <= '0;
         rv_r  <= 1'b0;
         rd_r  <= amm_pkg::SMP_RST;
         rc_r  <= '0;
         ov_r  <= 1'b0;
         od_r  <= amm_pkg::SMP_RST;
         pk_r  <= amm_pkg::PEAK_RST;
         ms_r  <= amm_pkg::MS_RST;
         for (int i = 0; i < NM; i++)
         begin
            peak_mem[i] <= amm_pkg::PEAK_RST;
            ms_mem[i]   <= amm_pkg::MS_RST;
         end
         for (int i = 0; i < NCH; i++)
         begin
            og_mem[i]   <= amm_pkg::OGAIN_RST;
            last_mem[i] <= amm_pkg::SMP_RST;
         end
      end
      else
      begin
         st_r  <= st_nxt;
         s_r   <= s_nxt;
         o_r   <= o_nxt;
         acc_r <= acc_nxt;
         rv_r  <= rv_nxt;
         rd_r  <= rd_nxt;
         rc_r  <= rc_nxt;
         ov_r  <= ov_nxt;
         od_r  <= od_nxt;
         pk_r  <= pk_nxt;
         ms_r  <= ms_nxt;
         // a clear meeting a new sample loses to the sample
         if (meter_clr)
            peak_mem[meter_sel] <= amm_pkg::PEAK_RST;
         if (m_we)
         begin
            peak_mem[m_idx] <= (m_mag > peak_mem[m_idx] || (meter_clr && meter_sel == m_idx))
                               ? m_mag : peak_mem[m_idx];
            ms_mem[m_idx]   <= ms_new;
         end
         if (og_we)
            og_mem[og_dst] <= og_val;
         if (st_r == amm_pkg::ST_FIN)
            last_mem[o_r] <= post;
      end
      if (pop)
         x_mem[f_src] <= f_data;
      if (gain_we)
         gain_mem[{gain_dst, gain_src}] <= gain_val;
   end

   assign rec_valid  = rv_r;
   assign rec_data   = rd_r;
   assign rec_chan   = rc_r;
   assign out_valid  = ov_r;
   assign out_data   = od_r;
   assign out_chan   = o_r;
   assign meter_peak = pk_r;
   assign meter_ms   = ms_r;

   //---------------------------------------------------------------
   // checks
   //---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   sequence s_mix_end;
      st_r == amm_pkg::ST_MIX && s_r == S_LAST;
   endsequence
   sequence s_emit_go;
      st_r == amm_pkg::ST_FIN ##1 out_valid;
   endsequence

   a_rec_pass_thru: assert property (pop && !f_src[SW-1] && !loop_en[f_src[OW-1:0]]
      |=> rec_valid && rec_data == $past(f_data)) else $error("record sample altered");
   a_rec_loopback: assert property (pop && !f_src[SW-1] && loop_en[f_src[OW-1:0]]
      |=> rec_data == $past(last_mem[f_src[OW-1:0]])) else $error("loopback not used");
   a_mix_walk: assert property (st_r == amm_pkg::ST_MIX && s_r != S_LAST
      |=> st_r == amm_pkg::ST_MIX && s_r == $past(s_r) + 1'b1) else $error("mix skipped");
   a_mix_to_out: assert property (s_mix_end |=> s_emit_go
      ##0 out_chan == $past(o_r, 2)) else $error("mix did not emit");
   a_sum_clamp: assert property (st_r == amm_pkg::ST_FIN
      && (acc_r >>> amm_pkg::GAIN_FRAC) > AW'(amm_pkg::SMAX) && og_mem[o_r] == amm_pkg::OGAIN_RST
      |=> out_data == amm_pkg::SMAX) else $error("sum wrapped");
   a_out_gain_zero: assert property (st_r == amm_pkg::ST_FIN && og_mem[o_r] == '0
      |=> out_valid && out_data == '0) else $error("output gain ignored");
   a_out_hold: assert property (out_valid && !out_ready
      |=> out_valid && $stable(out_data) && $stable(out_chan)) else $error("output dropped");
   a_pre_meter: assert property (pop |=> peak_mem[$past(f_src)]
      >= $past(m_mag)) else $error("input meter missed");
   a_post_meter: assert property (st_r == amm_pkg::ST_FIN |=> peak_mem[MW'(2 * NCH)
      + MW'($past(o_r))] >= (out_data[DW-1] ? DW'(-out_data) : out_data))
      else $error("output meter missed");
   a_gain_route: assert property (st_r == amm_pkg::ST_MIX && gain_mem[{o_r, s_r}] == '0
      |=> acc_r == $past(acc_r)) else $error("zero gain leaked");
endmodule

// *** amm_host_model.sv ***
// host driver model: takes the record stream and the mixed output stream
// assumes the mixer's clk; ready changes only at the falling edge
`timescale 1ns/1ps
module amm_host_model #(
   parameter int OW = 2
) (
   input  wire logic                         clk,       // sample clock
   input  wire logic                         reset_n,   // sync reset, low
   input  wire logic                         slow,      // stall now and then
   input  wire logic                         rec_valid, // record offered
   output logic                              rec_ready, // record accepted
   input  wire logic [amm_pkg::SAMPLE_W-1:0] rec_data,  // record sample
   input  wire logic [OW-1:0]                rec_chan,  // record channel
   input  wire logic                         out_valid, // mixed sample offered
   output logic                              out_ready, // mixed sample accepted
   input  wire logic [amm_pkg::SAMPLE_W-1:0] out_data,  // mixed sample
   input  wire logic [OW-1:0]                out_chan   // output channel
);
   logic [31:0] rec_q[$]; // accepted records, channel above sample
   logic [31:0] out_q[$]; // accepted outputs, channel above sample
   // ready pattern: prompt, or a slow host that accepts one edge in four
   always @(negedge clk)
   begin
      rec_ready <= reset_n && (!slow || $urandom_range(3) == 0);
      out_ready <= reset_n && (!slow || $urandom_range(3) == 0);
   end
   // keep every unit taken at a rising edge
   always @(posedge clk)
   begin
      if (reset_n && rec_valid && rec_ready) rec_q.push_back(32'({rec_chan, rec_data}));
      if (reset_n && out_valid && out_ready) out_q.push_back(32'({out_chan, out_data}));
   end
endmodule

// *** tb.sv ***
// self-checking bench of the matrix mixer with four channels of each kind
// assumes amm_pkg, amm_mixer and amm_host_model are compiled before it
`timescale 1ns/1ps
module tb;
   localparam int N = 4;
   localparam int SW = 3;
   localparam int OW = 2;
   localparam int MW = 4;
   logic              clk, reset_n, in_valid, in_ready, in_last, rec_valid, rec_ready;
   logic              out_valid, out_ready, gain_we, og_we, meter_clr, slow;
   logic [23:0]       in_data, rec_data, out_data, meter_peak;
   logic [SW-1:0]     in_src, gain_src;
   logic [OW-1:0]     rec_chan, out_chan, gain_dst, og_dst;
   logic [N-1:0]      loop_en;
   logic [15:0]       gain_val, og_val;
   logic [MW-1:0]     meter_sel;
   logic [47:0]       meter_ms, ms[3*N];
   logic signed [23:0] src_v[2*N], last_out[N];
   logic signed [15:0] g[N][2*N], og[N];
   logic [23:0]       pk[3*N];
   logic [31:0]       exp_rec[$], exp_out[$];
   int                n_mismatch, total_checks, cyc, refused;
   amm_mixer #(.NCH(N)) dut (.clk(clk), .reset_n(reset_n), .in_valid(in_valid),
      .in_ready(in_ready), .in_data(in_data), .in_src(in_src), .in_last(in_last),
      .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data), .rec_chan(rec_chan),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_chan(out_chan),
      .loop_en(loop_en), .gain_we(gain_we), .gain_dst(gain_dst), .gain_src(gain_src),
      .gain_val(gain_val), .og_we(og_we), .og_dst(og_dst), .og_val(og_val),
      .meter_sel(meter_sel), .meter_clr(meter_clr), .meter_peak(meter_peak), .meter_ms(meter_ms));
   amm_host_model #(.OW(OW)) host (.clk(clk), .reset_n(reset_n), .slow(slow),
      .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data), .rec_chan(rec_chan),
      .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data), .out_chan(out_chan));
   //----------------------------------------------------------------
   // clock, timeout and helpers
   //----------------------------------------------------------------
   always #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end
   function automatic logic signed [23:0] sat(input logic signed [63:0] v);
      if (v > 64'sh7FFFFF) return 24'sh7FFFFF;
      if (v < -64'sh800000) return 24'sh800000;
      return v[23:0];
   endfunction
   function automatic logic [23:0] mag(input logic signed [23:0] v);
      return v[23] ? 24'(-v) : v;
   endfunction
   // expected peak hold and leaky mean square of one meter
   function automatic void upd(input int i, input logic signed [23:0] v);
      logic [47:0] sq;
      sq = mag(v) * mag(v);
      if (mag(v) > pk[i]) pk[i] = mag(v);
      ms[i] = ms[i] - (ms[i] >> 8) + (sq >> 8);
   endfunction
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   //----------------------------------------------------------------
   // drivers: all called at a falling edge
   //----------------------------------------------------------------
   // every routing gain and output gain; big gives full-scale routing gains
   task automatic set_gains(input bit big);
      for (int o = 0; o < N; o++)
      begin
         for (int s = 0; s < 2*N; s++)
         begin
            if (big) g[o][s] = (o % 2) ? -16'sh7FFF : 16'sh7FFF;
            else if (s == o) g[o][s] = '0; // one silent route per output
            else g[o][s] = 16'($urandom_range(32'h1FFF) - 32'h800);
            gain_we = 1'b1;
            gain_dst = o[OW-1:0];
            gain_src = s[SW-1:0];
            gain_val = g[o][s];
            @(negedge clk);
         end
         gain_we = 1'b0;
         if (big) og[o] = (o == 0) ? 16'sh1000 : 16'sh4000; // unity on output 0
         else og[o] = (o == N - 1) ? 16'sh0000 : 16'($urandom_range(32'h1FFF)); // last muted
         og_we = 1'b1;
         og_dst = o[OW-1:0];
         og_val = og[o];
         @(negedge clk);
         og_we = 1'b0;
      end
   endtask
   // one frame: every source reps times, expectations worked out alongside
   task automatic frame(input int reps, input bit big);
      logic [31:0]        w[$];
      logic signed [63:0] acc;
      logic signed [23:0] v, m;
      int                 t;
      for (int r = 0; r < reps; r++)
         for (int s = 0; s < 2*N; s++)
         begin
            v = big ? 24'sh7FFFFF : 24'($urandom_range(32'h1FFFFE) - 32'hFFFFF);
            src_v[s] = v;
            upd(s, v);
            if (s < N) exp_rec.push_back(32'({s[OW-1:0], (loop_en[s] ? last_out[s] : v)}));
            w.push_back({s[7:0], v});
         end
      for (int o = 0; o < N; o++)
      begin
         acc = 0;
         for (int s = 0; s < 2*N; s++) acc += src_v[s] * g[o][s];
         m = sat(acc >>> 12);
         acc = m * og[o];
         m = sat(acc >>> 12);
         last_out[o] = m;
         exp_out.push_back(32'({o[OW-1:0], m}));
         upd(2*N+o, m);
      end
      foreach (w[i])
      begin
         in_valid = 1'b1;
         in_src = w[i][24 +: SW];
         in_data = w[i][23:0];
         in_last = (i == w.size() - 1);
         t = 0;
         while (in_ready !== 1'b1 && t < 5000)
         begin
            @(negedge clk);
            t++;
         end
         if (t > 0) refused++;
         @(negedge clk);
      end
      in_valid = 1'b0;
      in_last = 1'b0;
   endtask
   // wait for the host to have everything, then compare in order
   task automatic collect();
      int t;
      t = 0;
      while ((host.out_q.size() < exp_out.size() || host.rec_q.size() < exp_rec.size()) && t < 9000)
      begin
         @(negedge clk);
         t++;
      end
      check(host.out_q.size(), exp_out.size());
      check(host.rec_q.size(), exp_rec.size());
      while (exp_out.size() > 0 && host.out_q.size() > 0)
         check(host.out_q.pop_front(), exp_out.pop_front());
      while (exp_rec.size() > 0 && host.rec_q.size() > 0)
         check(host.rec_q.pop_front(), exp_rec.pop_front());
      exp_out.delete();
      exp_rec.delete();
   endtask
   // every peak meter, then a clear of the first one
   task automatic meters();
      for (int i = 0; i < 3*N; i++)
      begin
         meter_sel = i[MW-1:0];
         @(negedge clk);
         check(meter_peak, pk[i]);
         check(meter_ms, ms[i]);
      end
      meter_sel = '0;
      meter_clr = 1'b1;
      @(negedge clk);
      meter_clr = 1'b0;
      pk[0] = '0;
      @(negedge clk);
      check(meter_peak, pk[0]);
   endtask
   //----------------------------------------------------------------
   // main sequence
   //----------------------------------------------------------------
   initial
   begin
      clk = 0; reset_n = 0; in_valid = 0; in_data = '0; in_src = '0; in_last = 0;
      loop_en = '0; gain_we = 0; gain_dst = '0; gain_src = '0; gain_val = '0;
      og_we = 0; og_dst = '0; og_val = '0; meter_sel = '0; meter_clr = 0; slow = 0;
      foreach (pk[i]) pk[i] = '0;
      foreach (ms[i]) ms[i] = '0;
      foreach (last_out[i]) last_out[i] = '0;
      void'($urandom(32'h20C93B79));
      repeat (6) @(negedge clk);
      reset_n = 1;
      check(in_ready, 1'b1);
      check({out_valid, rec_valid, meter_peak}, '0);
      set_gains(0);
      frame(1, 0);
      collect();
      meters();
      // loopback on a random set of channels across two frames
      loop_en = 4'($urandom) | 4'h1;
      frame(1, 0);
      frame(1, 0);
      collect();
      // slow host while a long frame overfills the fifo
      slow = 1;
      frame(1, 0);
      frame(8, 0);
      collect();
      check(refused > 0, 1'b1);
      check(in_ready, 1'b1);
      slow = 0;
      set_gains(1);
      frame(1, 1);
      collect();
      meters();
      give_verdict();
   end
endmodule
